// file: udc_pkg.sv
// ************************************************************
// shared constants of the up/down counter block
// ************************************************************
package udc_pkg;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
    localparam logic [CNT_W-1:0] CNT_MIN = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

    // axi4-lite register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PRESET = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

    // control register fields
    localparam int CTRL_EN_LOW_BIT = 0;
    localparam int CTRL_DOWN_BIT = 1;
    localparam int CTRL_LOAD_LOW_BIT = 2;
    localparam int CTRL_STEP_BIT = 3;
    localparam int CTRL_SW_SRC_BIT = 4;
    localparam int CTRL_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h05;

    // status register fields
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_TERM_BIT = 4;
    localparam int STAT_RIPPLE_BIT = 5;

    // synchroniser lanes: count_clk, load_low, enable_low, down, preset[3:0]
    localparam int SYNC_W = 8;
    localparam logic [SYNC_W-1:0] SYNC_RST = 8'hff;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: udc_sync.sv
`timescale 1ns/1ns
// ************************************************************
// two-flop synchroniser, one lane per pin
// ************************************************************
module udc_sync
    import udc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [SYNC_W-1:0] async_in,
    output logic [SYNC_W-1:0] sync_out
);
    logic [SYNC_W-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_lane
            // first stage feeds only the second stage
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_q[i] <= SYNC_RST[i];
                    sync_out[i] <= SYNC_RST[i];
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule

// file: udc_core.sv
`timescale 1ns/1ns
// ************************************************************
// four-bit up/down count register
// ************************************************************
module udc_core
    import udc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic count_enable_low,
    input wire logic count_down,
    input wire logic load_low,
    input wire logic [CNT_W-1:0] preset_data,
    output logic [CNT_W-1:0] count_q
);
    logic [CNT_W-1:0] count_d;
    logic [CNT_W-1:0] step_val;

    // modulo arithmetic gives both wraps for free
    assign step_val = count_down ? count_q - 4'h1 : count_q + 4'h1;  // [R5] [R8] [R9]

    always_comb begin
        count_d = count_q;
        if (!load_low) begin
            count_d = preset_data;  // [R7]
        end else if (tick && !count_enable_low) begin
            count_d = step_val;  // [R3]
        end
    end

    // one register for all bits, so every output bit moves together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= CNT_RST;
        end else begin
            count_q <= count_d;  // [R2] [R4] [R6]
        end
    end
endmodule

// file: udc_top.sv
`timescale 1ns/1ns
// ************************************************************
// Notes on behaviour
// (R1) four-bit count, up or down, on outputs
// (R2) all count bits change on one edge
// (R3) enabled low enable: advance one step per edge
// (R4) enable high holds the count
// (R5) direction low counts up, high counts down
// (R6) control changes act only at clock edge
// (R7) load low forces preset data onto count
// (R8) counting up wraps fifteen to zero
// (R9) counting down wraps zero to fifteen
// (R10) terminal flag high at end count
// (R11) ripple pulse low at end, clock low
// (R12) cascade ripple into enable or clock
// (R13) terminal flag serves look-ahead carry
// (R14) reload preset to build modulo-n divider
// (R15) flags decoded combinationally from count, direction
// (R16) ripple pulse also needs enable low
// (R17) bit zero is least significant
// ************************************************************
module udc_top
    import udc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // counter pins
    input wire logic count_clk,
    input wire logic load_low,
    input wire logic count_enable_low,
    input wire logic count_down,
    input wire logic [CNT_W-1:0] preset_data,
    output logic [CNT_W-1:0] count_outputs,
    output logic terminal_flag,
    output logic ripple_pulse_low,
    // axi4-lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    // ************************************************************
    // pin synchronisation
    // ************************************************************
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_s;
    logic clk_s;
    logic load_low_s;
    logic en_low_s;
    logic down_s;
    logic [CNT_W-1:0] preset_s;
    logic clk_prev_q;

    // preset_data[0] is lane 4, the lsb of the preset lanes; lane 0 is count_clk
    assign pin_raw = {preset_data, count_down, count_enable_low, load_low, count_clk};  // [R17]
    assign clk_s = pin_s[0];
    assign load_low_s = pin_s[1];
    assign en_low_s = pin_s[2];
    assign down_s = pin_s[3];
    assign preset_s = pin_s[7:4];

    udc_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    // edge detect looks only at the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_prev_q <= 1'b1;
        end else begin
            clk_prev_q <= clk_s;
        end
    end

    // ************************************************************
    // software control registers
    // ************************************************************
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic [CNT_W-1:0] preset_reg_q;
    logic [CNT_W-1:0] preset_reg_d;
    logic step_q;
    logic step_d;

    // ************************************************************
    // control source selection
    // ************************************************************
    wire sw_src = ctrl_q[CTRL_SW_SRC_BIT];
    wire pin_tick = clk_s & ~clk_prev_q;
    // software mode has no clock phase; the step pulse stands in for the high phase
    wire clk_low = sw_src ? ~step_q : ~clk_s;
    wire tick = sw_src ? step_q : pin_tick;
    wire en_low_eff = sw_src ? ctrl_q[CTRL_EN_LOW_BIT] : en_low_s;
    wire down_eff = sw_src ? ctrl_q[CTRL_DOWN_BIT] : down_s;
    wire load_low_eff = sw_src ? ctrl_q[CTRL_LOAD_LOW_BIT] : load_low_s;
    wire [CNT_W-1:0] preset_eff = sw_src ? preset_reg_q : preset_s;

    // ************************************************************
    // counter and cascade outputs
    // ************************************************************
    logic [CNT_W-1:0] count_q;

    udc_core u_core (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .count_enable_low(en_low_eff),
        .count_down(down_eff),
        .load_low(load_low_eff),
        .preset_data(preset_eff),
        .count_q(count_q)
    );

    assign count_outputs = count_q;  // [R1]

    // direction change updates flags at once, no edge needed
    wire at_end = down_eff ? (count_q == CNT_MIN) : (count_q == CNT_MAX);  // [R15]
    assign terminal_flag = at_end;  // [R10] [R13]
    // gated by enable so a held stage does not fire the next one
    assign ripple_pulse_low = ~(at_end & ~en_low_eff & clk_low);  // [R11] [R16] [R12]

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    assign awready = ~aw_held_q & ~bvalid_q;
    assign wready = ~w_held_q & ~bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    wire aw_take = awvalid & awready;
    wire w_take = wvalid & wready;
    wire aw_ok = aw_held_q | aw_take;
    wire w_ok = w_held_q | w_take;
    wire do_write = aw_ok & w_ok & ~bvalid_q;
    wire [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : wdata;
    wire [3:0] wr_strb = w_held_q ? wstrb_q : wstrb;
    wire wr_lane0 = do_write & wr_strb[0];
    wire wr_ctrl = wr_lane0 & (wr_addr == OFS_CTRL);
    wire wr_preset = wr_lane0 & (wr_addr == OFS_PRESET);
    wire wr_mapped = (wr_addr == OFS_CTRL) | (wr_addr == OFS_PRESET) | (wr_addr == OFS_STATUS);

    always_comb begin
        ctrl_d = ctrl_q;
        preset_reg_d = preset_reg_q;
        step_d = 1'b0;
        if (wr_ctrl) begin
            ctrl_d = wr_data[CTRL_W-1:0];
            ctrl_d[CTRL_STEP_BIT] = 1'b0;
            step_d = wr_data[CTRL_STEP_BIT];
        end
        if (wr_preset) begin
            preset_reg_d = wr_data[CNT_W-1:0];  // [R14]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
            preset_reg_q <= CNT_RST;
            step_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            preset_reg_q <= preset_reg_d;
            step_q <= step_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_q <= awaddr;
            end
            if (w_take) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else begin
                aw_held_q <= aw_ok;
                w_held_q <= w_ok;
                if (bvalid_q && bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rd_word;

    assign arready = ~rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    wire ar_take = arvalid & arready;
    wire rd_ctrl = araddr == OFS_CTRL;
    wire rd_preset = araddr == OFS_PRESET;
    wire rd_status = araddr == OFS_STATUS;

    always_comb begin
        rd_word = 32'h0;
        if (rd_ctrl) begin
            rd_word[CTRL_W-1:0] = ctrl_q;
        end
        if (rd_preset) begin
            rd_word[CNT_W-1:0] = preset_reg_q;
        end
        if (rd_status) begin
            rd_word[STAT_CNT_LSB +: CNT_W] = count_q;
            rd_word[STAT_TERM_BIT] = terminal_flag;
            rd_word[STAT_RIPPLE_BIT] = ripple_pulse_low;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= (rd_ctrl | rd_preset | rd_status) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule

// file: udc_checker.sv
`timescale 1ns/1ns
// ************************************************************
// port-level checks of the up/down counter
// ************************************************************
module udc_checker
    import udc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic count_clk,
    input wire logic load_low,
    input wire logic count_enable_low,
    input wire logic count_down,
    input wire logic [CNT_W-1:0] preset_data,
    input wire logic [CNT_W-1:0] count_outputs,
    input wire logic terminal_flag,
    input wire logic ripple_pulse_low
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // five samples span the two-flop pin synchroniser plus the count register
    chk_load_force: assert property (
        (!load_low && $stable(preset_data))[*5] |-> ##1 count_outputs == preset_data)
        else $error("count does not follow preset while load is low");
    chk_hold_off: assert property (
        (count_enable_low && load_low)[*5] |=> $stable(count_outputs))
        else $error("count moved while enable was high");
    chk_up_step: assert property (
        (load_low && !count_down)[*5] ##1 $changed(count_outputs)
        |-> count_outputs == $past(count_outputs) + 4'h1)
        else $error("up count did not advance by one");
    chk_down_step: assert property (
        (load_low && count_down)[*5] ##1 $changed(count_outputs)
        |-> count_outputs == $past(count_outputs) - 4'h1)
        else $error("down count did not step back by one");
    chk_term_set: assert property (
        ((!count_down)[*4] ##0 count_outputs == CNT_MAX)
        or (count_down[*4] ##0 count_outputs == CNT_MIN) |-> terminal_flag)
        else $error("terminal flag missing at end count");
    chk_term_only: assert property (
        terminal_flag |-> count_outputs == CNT_MAX || count_outputs == CNT_MIN)
        else $error("terminal flag away from end count");
    chk_ripple_on: assert property (
        (!count_enable_low && !count_clk)[*4] ##0 terminal_flag |-> !ripple_pulse_low)
        else $error("ripple pulse missing");
    chk_ripple_term: assert property (
        !ripple_pulse_low |-> terminal_flag)
        else $error("ripple pulse without terminal flag");
    chk_ripple_gate: assert property (
        count_enable_low[*4] |-> ripple_pulse_low)
        else $error("ripple pulse while enable is high");
endmodule

bind udc_top udc_checker i_chk (.aclk, .aresetn, .count_clk, .load_low, .count_enable_low,
    .count_down, .preset_data, .count_outputs, .terminal_flag, .ripple_pulse_low);

// file: udc_pins.sv
`timescale 1ns/1ns
// ************************************************************
// model of the control logic driving the counter pins
// ************************************************************
module udc_pins
    import udc_pkg::*;
(
    output logic count_clk,
    output logic load_low,
    output logic count_enable_low,
    output logic count_down,
    output logic [CNT_W-1:0] preset_data,
    input wire logic aclk
);
    initial begin
        count_clk = 1'b0;
        load_low = 1'b1;
        count_enable_low = 1'b1;
        count_down = 1'b0;
        preset_data = 4'h0;
    end
    // four idle cycles let the pin synchroniser settle before any tick
    task automatic set_pins(input logic ld, en, dn, input logic [CNT_W-1:0] pre);
        @(posedge aclk);
        load_low <= ld;
        count_enable_low <= en;
        count_down <= dn;
        preset_data <= pre;
        repeat (4) @(posedge aclk);
    endtask
    // phases of four cycles; the synchroniser catches any phase that lasts one aclk cycle or more
    task automatic tick(input int n);
        repeat (n) begin
            count_clk <= 1'b1;
            repeat (4) @(posedge aclk);
            count_clk <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
endmodule

// file: udc_top_tb.sv
`timescale 1ns/1ns
// ************************************************************
// self-checking bench of the up/down counter
// ************************************************************
module udc_top_tb;
    import udc_pkg::*;
    typedef struct packed {
        logic ld, en, dn;
        logic [3:0] pre;
        logic [1:0] n;
        logic [3:0] cnt;
        logic tf;
    } udc_row_s;
    logic aclk, aresetn, count_clk, load_low, count_enable_low, count_down;
    logic terminal_flag, ripple_pulse_low, awvalid, awready, wvalid, wready;
    logic bvalid, bready, arvalid, arready, rvalid, rready;
    logic [3:0] preset_data, count_outputs, awaddr, araddr;
    logic [1:0] bresp, rresp;
    logic [31:0] wdata, rdata;
    int errors = 0;
    int compares = 0;
    udc_row_s rows [12] = '{'{0,1,0,4'hd,0,4'hd,0}, '{1,0,0,4'hd,1,4'he,0},
        '{1,0,0,4'hd,1,4'hf,1}, '{1,0,0,4'hd,1,4'h0,0}, '{1,0,0,4'hd,2,4'h2,0},
        '{1,1,0,4'hd,2,4'h2,0}, '{1,0,1,4'hd,2,4'h0,1}, '{1,0,1,4'hd,1,4'hf,0},
        '{1,0,1,4'hd,2,4'hd,0}, '{0,0,1,4'h0,1,4'h0,1}, '{1,1,0,4'h0,0,4'h0,0},
        '{0,1,0,4'h9,0,4'h9,0}};
    udc_top i_dut (.aclk, .aresetn, .count_clk, .load_low, .count_enable_low, .count_down,
        .preset_data, .count_outputs, .terminal_flag, .ripple_pulse_low, .awvalid, .awready,
        .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
    udc_pins i_pin (.count_clk, .load_low, .count_enable_low, .count_down, .preset_data, .aclk);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ready is sampled at the falling edge, where it is settled, and acted on at the next rise
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ah, wh, done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int k = 0; k < 40 && !done; k++) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            if (bvalid) begin
                check("bresp", 32'(bresp), 32'(r));
                done = 1'b1;
            end
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        if (!done) errors++;
        if (!done) end_of_test();
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ah, done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int k = 0; k < 40 && !done; k++) begin
            @(negedge aclk);
            ah = arvalid && arready;
            if (rvalid) begin
                check("rdata", rdata, d);
                check("rresp", 32'(rresp), 32'(r));
                done = 1'b1;
            end
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) errors++;
        if (!done) end_of_test();
    endtask
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            i_pin.set_pins(rows[i].ld, rows[i].en, rows[i].dn, rows[i].pre);
            i_pin.tick(32'(rows[i].n));
            repeat (6) @(posedge aclk);
            check("count", 32'(count_outputs), 32'(rows[i].cnt));
            check("term", 32'(terminal_flag), 32'(rows[i].tf));
            check("ripple", 32'(ripple_pulse_low), 32'(!(rows[i].tf && !rows[i].en)));
            $display("row %0d done", i);
        end
        axi_rd(OFS_STATUS, 32'h29, RESP_OKAY);
        axi_wr(OFS_CTRL, 32'he5, RESP_OKAY);
        axi_rd(OFS_CTRL, 32'h05, RESP_OKAY);
        axi_wr(OFS_PRESET, 32'h07, RESP_OKAY);
        axi_rd(OFS_PRESET, 32'h07, RESP_OKAY);
        axi_wr(OFS_STATUS, 32'h00, RESP_OKAY);
        axi_rd(OFS_STATUS, 32'h29, RESP_OKAY);
        axi_wr(4'hc, 32'h01, RESP_SLVERR);
        axi_rd(4'hc, 32'h00, RESP_SLVERR);
        $display("register test done");
        i_pin.set_pins(1'b1, 1'b1, 1'b0, 4'h9);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("reset count", 32'(count_outputs), 32'(CNT_RST));
        axi_rd(OFS_CTRL, 32'(CTRL_RST), RESP_OKAY);
        axi_rd(OFS_PRESET, 32'h00, RESP_OKAY);
        $display("reset test done");
        // pins keep load high, enable low, up and clock low, so only the software step moves the count
        i_pin.set_pins(1'b1, 1'b0, 1'b0, 4'h0);
        axi_wr(OFS_CTRL, 32'h1c, RESP_OKAY);
        axi_rd(OFS_STATUS, 32'h21, RESP_OKAY);
        axi_rd(OFS_CTRL, 32'h14, RESP_OKAY);
        $display("software step test done");
        end_of_test();
    end
endmodule
